// file: design/siolm_bus_if.sv
// register port bundle between top and register file
`timescale 1ns/1ns
interface siolm_bus_if;
  logic [3:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [15:0] sel;
  logic [15:0] pad;
  logic [1:0] stat;
  modport regs (input addr, wdata, wr, rd, stat, output rdata, sel, pad);
  modport core (output addr, wdata, wr, rd, stat, input rdata, sel, pad);
endinterface

// file: design/siolm_pkg.sv
// constants for the system i/o line multiplexer
package siolm_pkg;
  // register indices on the plain register port (byte addr = 4 * index)
  localparam logic [3:0] REG_SEL = 4'h0;    // selection bits
  localparam logic [3:0] REG_PAD = 4'h1;    // pad settings
  localparam logic [3:0] REG_STAT = 4'h2;   // debug port status
  localparam int SEL_W = 16;
  localparam int BIT_DEBUG_LO = 4;
  localparam int BIT_DEBUG_HI = 7;
  localparam int BIT_USB_DM = 10;
  localparam int BIT_USB_DP = 11;
  localparam int BIT_ERASE = 12;
  localparam logic [15:0] SEL_MASK = 16'h1cf0;
  localparam logic [15:0] SEL_RESET = 16'h0000;
  localparam int PAD_W = 16;
  localparam logic [15:0] PAD_RESET = 16'h0000;
  // status bit positions
  localparam int STAT_SWD = 0;
  localparam int STAT_BSCAN = 1;
  // jtag-to-swd switching sequence on swdio, lsb first
  localparam logic [15:0] SWITCH_SEQ = 16'he79e;
  localparam int SWITCH_LEN = 16;
  localparam int LINE_RESET_LEN = 50;
  typedef enum logic [1:0] {
    SIOLM_DP_JTAG,
    SIOLM_DP_SWD
  } siolm_dp_t;
endpackage

// file: design/siolm_regs.sv
// selection and pad register file
`timescale 1ns/1ns
module siolm_regs (
  input wire logic clk_i,            // system clock
  input wire logic rst_i,            // sync reset, high
  siolm_bus_if.regs bus              // register bundle
);
  logic [15:0] sel_q;
  logic [15:0] pad_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  wire wr_sel = bus.wr && (bus.addr == siolm_pkg::REG_SEL);
  wire wr_pad = bus.wr && (bus.addr == siolm_pkg::REG_PAD);
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (bus.addr)
      siolm_pkg::REG_SEL: rdata_d = {16'h0000, sel_q};
      siolm_pkg::REG_PAD: rdata_d = {16'h0000, pad_q};
      siolm_pkg::REG_STAT: rdata_d = {30'h0000_0000, bus.stat};
      default: rdata_d = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q <= siolm_pkg::SEL_RESET;
      pad_q <= siolm_pkg::PAD_RESET;
      rdata_q <= 32'h0000_0000;
    end else begin
      if (wr_sel) sel_q <= bus.wdata[15:0] & siolm_pkg::SEL_MASK;
      if (wr_pad) pad_q <= bus.wdata[15:0];
      rdata_q <= bus.rd ? rdata_d : 32'h0000_0000;
    end
  end
  assign bus.sel = sel_q;
  assign bus.pad = pad_q;
  assign bus.rdata = rdata_q;
endmodule // siolm_regs

// file: design/siolm_top.sv
// system i/o line multiplexer top
`timescale 1ns/1ns
// Function
// - reset returns every system line to its default system function.
// - one selection bit per shared line: 4-7 debug, 10-11 usb, 12 erase.
// - debug pins start in debug mode for probe connection.
// - software register switches each debug pin between debug and port.
// - pad pull-up, trigger, debounce, glitch settings apply in both modes.
// - boundary scan only when test select high and slow crystal line low.
// - after reset four-wire debug port active, serial-wire disabled.
// - trace output on tdo pin only while serial-wire port active.
module siolm_top (
  input wire logic clk_i,                        // system clock, 10 MHz
  input wire logic rst_i,                        // sync reset, high
  input wire logic [3:0] reg_addr_i,             // register index
  input wire logic [31:0] reg_wdata_i,           // write data
  input wire logic reg_wr_i,                     // write strobe
  input wire logic reg_rd_i,                     // read strobe
  output logic [31:0] reg_rdata_o,               // read data, next cycle
  input wire logic test_select_input_i,          // test select pin
  input wire logic slow_crystal_in_port_line_i,  // slow crystal port line in
  input wire logic tck_swclk_i,                  // debug clock pin
  input wire logic tms_swdio_i,                  // debug mode/data pin
  input wire logic tdi_i,                        // debug data in pin
  input wire logic erase_i,                      // flash clear pin
  input wire logic usb_data_minus_i,             // usb d- pin in
  input wire logic usb_data_plus_i,              // usb d+ pin in
  input wire logic [15:0] port_out_i,            // port b output values
  input wire logic [15:0] port_oe_n_i,           // port b enables, low drives
  input wire logic jtag_tdo_i,                   // tdo from four-wire port
  input wire logic jtag_tdo_oe_n_i,              // tdo enable, low drives
  input wire logic swdio_out_i,                  // swdio data from port
  input wire logic swdio_oe_n_i,                 // swdio enable, low drives
  input wire logic trace_i,                      // async trace data
  input wire logic trace_en_i,                   // trace enabled by debug
  input wire logic [15:0] usb_out_i,             // usb pad outputs, bits 10-11
  input wire logic [15:0] usb_oe_n_i,            // usb pad enables, low drives
  output logic [15:0] pad_out_o,                 // pad output values
  output logic [15:0] pad_oe_n_o,                // pad enables, low drives
  output logic [15:0] pad_cfg_o,                 // pad pull/trigger/filter
  output logic [15:0] port_in_o,                 // inputs seen by port b
  output logic port_b_line_twelve_o,             // erase line as port input
  output logic port_b_line_ten_o,                // usb d- line as port input
  output logic port_b_line_eleven_o,             // usb d+ line as port input
  output logic flash_erase_o,                    // erase request to flash
  output logic usb_data_minus_o,                 // d- to usb core
  output logic usb_data_plus_o,                  // d+ to usb core
  output logic four_wire_debug_port_en_o,        // jtag port enabled
  output logic serial_wire_debug_port_en_o,      // swd port enabled
  output logic boundary_scan_o,                  // boundary scan mode
  output logic [3:0] debug_sys_o                 // debug pins in system mode
);
  siolm_bus_if bus ();
  siolm_pkg::siolm_dp_t dp_q;
  logic [15:0] shift_q;
  logic [5:0] ones_q;
  logic tck_q;
  logic bscan_q;
  logic [15:0] pad_out_q;
  logic [15:0] pad_oe_n_q;
  logic [15:0] port_in_q;
  logic [15:0] sys_out;
  logic [15:0] sys_oe_n;
  logic [15:0] pin_in;
  logic [15:0] sel;

  // ===========================================================
  // register file
  assign bus.addr = reg_addr_i;
  assign bus.wdata = reg_wdata_i;
  assign bus.wr = reg_wr_i;
  assign bus.rd = reg_rd_i;
  assign bus.stat = {bscan_q, dp_q == siolm_pkg::SIOLM_DP_SWD};
  siolm_regs u_regs (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bus (bus)
  );
  assign reg_rdata_o = bus.rdata;
  assign sel = bus.sel;
  assign pad_cfg_o = bus.pad;

  // ===========================================================
  // debug port selection
  wire tck_rise = tck_swclk_i && !tck_q;
  wire [15:0] shift_d = {tms_swdio_i, shift_q[15:1]};
  wire line_reset = ones_q >= 6'(siolm_pkg::LINE_RESET_LEN);
  wire seq_hit = line_reset && (shift_d == siolm_pkg::SWITCH_SEQ);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dp_q <= siolm_pkg::SIOLM_DP_JTAG;
      shift_q <= 16'h0000;
      ones_q <= 6'h00;
      tck_q <= 1'b0;
    end else begin
      tck_q <= tck_swclk_i;
      if (tck_rise) begin
        shift_q <= shift_d;
        // once armed, zeros of the switch pattern must not disarm the detector
        if (!line_reset && !tms_swdio_i) ones_q <= 6'h00;
        else if (!line_reset) ones_q <= ones_q + 6'h01;
        if (seq_hit) dp_q <= siolm_pkg::SIOLM_DP_SWD;
      end
    end
  end
  assign four_wire_debug_port_en_o = dp_q == siolm_pkg::SIOLM_DP_JTAG;
  assign serial_wire_debug_port_en_o = dp_q == siolm_pkg::SIOLM_DP_SWD;

  // ===========================================================
  // boundary scan select
  wire bscan_d = test_select_input_i && !slow_crystal_in_port_line_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) bscan_q <= 1'b0;
    else bscan_q <= bscan_d;
  end
  assign boundary_scan_o = bscan_q;

  // ===========================================================
  // system-side pad drive
  wire swd = dp_q == siolm_pkg::SIOLM_DP_SWD;
  wire tdo_trace = swd && trace_en_i;
  always_comb begin
    sys_out = usb_out_i;
    sys_oe_n = usb_oe_n_i | ~(16'h0001 << siolm_pkg::BIT_USB_DM)
                          & ~(16'h0001 << siolm_pkg::BIT_USB_DP);
    sys_out[5] = tdo_trace ? trace_i : jtag_tdo_i;
    sys_oe_n[5] = tdo_trace ? 1'b0 : (swd | jtag_tdo_oe_n_i);
    sys_out[6] = swdio_out_i;
    sys_oe_n[6] = !swd | swdio_oe_n_i;
  end

  // ===========================================================
  // per-line mux
  always_comb begin
    pin_in = 16'h0000;
    pin_in[4] = tdi_i;
    pin_in[5] = 1'b0;
    pin_in[6] = tms_swdio_i;
    pin_in[7] = tck_swclk_i;
    pin_in[siolm_pkg::BIT_USB_DM] = usb_data_minus_i;
    pin_in[siolm_pkg::BIT_USB_DP] = usb_data_plus_i;
    pin_in[siolm_pkg::BIT_ERASE] = erase_i;
  end
  wire [15:0] port_own = sel & siolm_pkg::SEL_MASK;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_out_q <= 16'h0000;
      pad_oe_n_q <= 16'hffff;
      port_in_q <= 16'h0000;
    end else begin
      pad_out_q <= (port_own & port_out_i) | (~port_own & sys_out);
      pad_oe_n_q <= (port_own & port_oe_n_i) | (~port_own & sys_oe_n);
      port_in_q <= pin_in & port_own;
    end
  end
  assign pad_out_o = pad_out_q;
  assign pad_oe_n_o = pad_oe_n_q;
  assign port_in_o = port_in_q;
  assign port_b_line_twelve_o = port_in_q[siolm_pkg::BIT_ERASE];
  assign port_b_line_ten_o = port_in_q[siolm_pkg::BIT_USB_DM];
  assign port_b_line_eleven_o = port_in_q[siolm_pkg::BIT_USB_DP];
  // erase is live only while the line is in system mode; board keeps it low
  assign flash_erase_o = !port_own[siolm_pkg::BIT_ERASE] && erase_i;
  assign usb_data_minus_o = !port_own[siolm_pkg::BIT_USB_DM] && usb_data_minus_i;
  assign usb_data_plus_o = !port_own[siolm_pkg::BIT_USB_DP] && usb_data_plus_i;
  assign debug_sys_o = ~port_own[siolm_pkg::BIT_DEBUG_HI:siolm_pkg::BIT_DEBUG_LO];
endmodule // siolm_top

// file: verif/siolm_asserts.sv
// port checker for the system i/o line multiplexer
`timescale 1ns/1ns
module siolm_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic test_select_input_i,
  input wire logic slow_crystal_in_port_line_i,
  input wire logic erase_i,
  input wire logic [15:0] port_oe_n_i,
  input wire logic [15:0] pad_oe_n_o,
  input wire logic flash_erase_o,
  input wire logic four_wire_debug_port_en_o,
  input wire logic serial_wire_debug_port_en_o,
  input wire logic boundary_scan_o,
  input wire logic [3:0] debug_sys_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire sel_wr = reg_wr_i && reg_addr_i == 4'h0;
  reset_state_a: assert property (disable iff (1'b0) rst_i |=> debug_sys_o == 4'hf
    && four_wire_debug_port_en_o && !serial_wire_debug_port_en_o) else $error("reset state");
  sel_write_a: assert property (sel_wr |=> debug_sys_o == ~$past(reg_wdata_i[7:4]))
    else $error("sel write");
  sel_hold_a: assert property (!sel_wr |=> $stable(debug_sys_o)) else $error("sel hold");
  erase_gate_a: assert property (flash_erase_o |-> erase_i) else $error("erase gate");
  dp_onehot_a: assert property (four_wire_debug_port_en_o != serial_wire_debug_port_en_o)
    else $error("port select");
  swd_sticky_a: assert property (serial_wire_debug_port_en_o |=> serial_wire_debug_port_en_o)
    else $error("swd dropped");
  bscan_cause_a: assert property (boundary_scan_o |-> $past(test_select_input_i)
    && !$past(slow_crystal_in_port_line_i)) else $error("bscan cause");
  bscan_set_a: assert property (test_select_input_i && !slow_crystal_in_port_line_i
    |=> boundary_scan_o) else $error("bscan set");
  port_pad_a: assert property (!debug_sys_o[0] |=> pad_oe_n_o[4] == $past(port_oe_n_i[4]))
    else $error("port pad");
  unmapped_a: assert property (reg_rd_i && reg_addr_i > 4'h2 |=> reg_rdata_o == 32'h0)
    else $error("unmapped read");
  cover property (serial_wire_debug_port_en_o);
  cover property (boundary_scan_o);
  cover property (sel_wr);
endmodule // siolm_asserts
bind siolm_top siolm_asserts u_siolm_asserts (.*);

// file: verif/siolm_probe.sv
// debug probe model that drives the serial-wire switch sequence
`timescale 1ns/1ns
module siolm_probe (
  input wire logic clk_i, // system clock
  input wire logic go_i,  // start one switch frame
  output logic tck_o,     // probe clock, still outside frames
  output logic tms_o      // probe mode/data line
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i === 1'b1) begin
        for (int i = 0; i < 66; i++) begin
          tms_o <= (i < 50) ? 1'b1 : siolm_pkg::SWITCH_SEQ[i - 50];
          repeat (2) @(posedge clk_i);
          tck_o <= 1'b1;
          repeat (2) @(posedge clk_i);
          tck_o <= 1'b0;
        end
        tms_o <= ~tms_o;
      end
    end
  end
endmodule // siolm_probe

// file: verif/siolm_top_tb.sv
// bench for the system i/o line multiplexer
`timescale 1ns/1ns
module siolm_top_tb;
  logic clk_i = 0, rst_i = 1, wr = 0, rd = 0, ts = 0, sl = 1, er = 0, dm = 0, go = 0;
  logic tdo = 0, tdon = 1, tr = 0, tre = 0, tck, tms, fe, udm, fw, sw, bs, p12;
  logic [3:0] ad = 4'h0, dsys;
  logic [31:0] wd = 32'h0, q, rq;
  logic [15:0] po = 16'h0010, pon = 16'hffef, pout, poen, pcfg;
  int mismatches = 0, checked = 0, cyc = 0;
  logic [3:0] ta[4] = '{4'h0, 4'h1, 4'h3, 4'h0};
  logic [31:0] tw[4] = '{32'hffff, 32'habcd, 32'h5555, 32'h0010};
  logic [31:0] te[4] = '{32'h1cf0, 32'habcd, 32'h0, 32'h0010};
  siolm_top u_siolm_top (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(ad), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rq), .test_select_input_i(ts),
    .slow_crystal_in_port_line_i(sl), .tck_swclk_i(tck), .tms_swdio_i(tms), .tdi_i(1'b0),
    .erase_i(er), .usb_data_minus_i(dm), .usb_data_plus_i(dm), .port_out_i(po),
    .port_oe_n_i(pon), .jtag_tdo_i(tdo), .jtag_tdo_oe_n_i(tdon), .swdio_out_i(1'b0),
    .swdio_oe_n_i(1'b1), .trace_i(tr), .trace_en_i(tre), .usb_out_i(16'h0),
    .usb_oe_n_i(16'hffff), .pad_out_o(pout), .pad_oe_n_o(poen), .pad_cfg_o(pcfg),
    .port_in_o(), .port_b_line_twelve_o(p12), .port_b_line_ten_o(), .port_b_line_eleven_o(),
    .flash_erase_o(fe), .usb_data_minus_o(udm), .usb_data_plus_o(),
    .four_wire_debug_port_en_o(fw), .serial_wire_debug_port_en_o(sw),
    .boundary_scan_o(bs), .debug_sys_o(dsys));
  siolm_probe u_siolm_probe (.clk_i(clk_i), .go_i(go), .tck_o(tck), .tms_o(tms));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    ad <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clk_i);
    ad <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 q = rq;
  endtask
  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(1);
    chk(dsys, 4'hf);
    chk({fw, sw, bs}, 3'b100);
    for (int i = 0; i < 4; i++) begin
      wreg(ta[i], tw[i]);
      rreg(ta[i]);
      chk(q, te[i]);
    end
    $display("register rows done");
    er <= 1'b1;
    dm <= 1'b1;
    tick(1);
    chk({fe, udm}, 2'b11);
    wreg(4'h0, 32'h1c10);
    tick(1);
    chk({fe, udm, p12, dsys}, 7'h1e);
    chk({pout[4], poen[4], pcfg}, 18'h2abcd);
    wreg(4'h0, 32'h0);
    er <= 1'b0;
    ts <= 1'b1;
    sl <= 1'b0;
    tick(2);
    chk(bs, 1'b1);
    sl <= 1'b1;
    tick(2);
    chk(bs, 1'b0);
    {ts, tre, tr, tdon} <= 4'b0110;
    tick(2);
    chk(pout[5], 1'b0);
    $display("pin tests done");
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    for (int i = 0; i < 400 && sw !== 1'b1; i++) tick(1);
    chk({fw, sw}, 2'b01);
    rreg(4'h2);
    chk(q, 32'h1);
    tick(1);
    chk(pout[5], 1'b1);
    rst_i <= 1'b1;
    tick(1);
    rst_i <= 1'b0;
    rreg(4'h0);
    chk({q, fw, sw}, 34'h2);
    $display("debug switch done");
    stop_test();
  end
endmodule // siolm_top_tb
